// ==== osd_cfg_pkg.sv ====
// register map, field layout and timing constants of the overlay window configuration bank
package osd_cfg_pkg;
	// byte addresses of the word-aligned registers
	localparam logic [4:0] ADDR_GFX_B_MODE = 5'h00;
	localparam logic [4:0] ADDR_ATTR_MODE = 5'h04;
	localparam logic [4:0] ADDR_CURSOR = 5'h08;
	localparam logic [4:0] ADDR_VIDEO_A_PITCH = 5'h0C;
	localparam logic [4:0] ADDR_VIDEO_B_PITCH = 5'h10;
	localparam logic [4:0] ADDR_GFX_A_PITCH = 5'h14;
	localparam logic [4:0] ADDR_STATUS = 5'h18;
	// storage slots of the register array, then the status and unmapped index codes
	localparam int NUM_REGS = 6;
	localparam logic [2:0] IDX_GFX_B = 3'h0;
	localparam logic [2:0] IDX_ATTR = 3'h1;
	localparam logic [2:0] IDX_CURSOR = 3'h2;
	localparam logic [2:0] IDX_VIDEO_A = 3'h3;
	localparam logic [2:0] IDX_VIDEO_B = 3'h4;
	localparam logic [2:0] IDX_GFX_A = 3'h5;
	localparam logic [2:0] IDX_STATUS = 3'h6;
	localparam logic [2:0] IDX_NONE = 3'h7;
	// writable bits per slot, slot 5 first; attribute enable lives in slot 0 only
	localparam logic [NUM_REGS-1:0][15:0] WR_MASK = {
		16'h01FF, 16'h01FF, 16'h01FF, 16'hFFFF, 16'h0FC3, 16'hFFFF};
	localparam logic [15:0] RESET_VALUE = 16'h0000;
	// window-b mode and attribute mode fields
	localparam int ATTR_EN_BIT = 15;
	localparam int ATTEN_BIT = 14;
	localparam int RGB_BIT = 13;
	localparam int TABLE_BIT = 12;
	localparam int HZOOM_LSB = 10;
	localparam int VZOOM_LSB = 8;
	localparam int BPP_LSB = 6;
	localparam int BLEND_LSB = 3;
	localparam int TRANSP_BIT = 2;
	localparam int FRAME_BIT = 1;
	localparam int ACTIVE_BIT = 0;
	localparam int BLINK_INT_LSB = 6;
	localparam int BLINK_EN_BIT = 0;
	// cursor fields
	localparam int CUR_INDEX_LSB = 8;
	localparam int CUR_TABLE_BIT = 7;
	localparam int CUR_H_LSB = 4;
	localparam int CUR_V_LSB = 1;
	localparam int CUR_ACTIVE_BIT = 0;
	// status fields
	localparam int STAT_BLINK_BIT = 0;
	localparam int STAT_PENDING_BIT = 1;
	// timing and format constants
	localparam int BURST_BYTES_LOG2 = 5;
	localparam logic [2:0] BLINK_UNIT_LAST = 3'h7;
	localparam logic [2:0] BLEND_FULL = 3'h7;
	localparam logic [3:0] WEIGHT_ONE = 4'h8;
	localparam logic [4:0] RGB_BPP = 5'h10;
endpackage : osd_cfg_pkg

// ==== osd_window_layer_config.sv ====
// overlay window, attribute, cursor and line pitch configuration with vsync-latched shadows
//
// How it works
// - colour table bit picks ROM or RAM
// - horizontal zoom codes give x1 x2 x4 x1
// - vertical zoom codes give x1 x2 x4 x1
// - bitmap width codes give 1 2 4 8 bits
// - blend n weights graphics n/8, 7 full
// - transparency limits blend to zero bitmap pixels
// - RGB pixel matching key gets blended
// - field mode reads each stored line per field
// - frame mode reads alternate lines, interlaced only
// - active bit shows window two when not attribute
// - attribute enable turns window two into attributes
// - attribute zooms use same code table
// - blink period is n+1 units of eight vsyncs
// - attribute frame mode and blink enable bits
// - cursor palette index and table select
// - cursor width four times n, zero gives one
// - cursor height two times n, zero gives one
// - cursor active bit shows cursor
// - video pitch counts 32-byte bursts per line
// - graphics pitch is pixels times depth over 256
`timescale 1ns/100ps
module osd_window_layer_config #(
	parameter int PIX_W = 8,
	parameter int LINE_W = 11
) (
	// clock, reset, enable
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic clk_en_i,
	// register bus
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// display timing
	input wire logic vertical_sync_pulse_i,
	input wire logic video_encoder_interlaced_i,
	input wire logic field_odd_i,
	input wire logic [LINE_W-1:0] display_line_i,
	// pixel path
	input wire logic pix_valid_i,
	input wire logic [7:0] gfx_index_i,
	input wire logic [15:0] gfx_rgb_i,
	input wire logic [15:0] transparency_key_i,
	input wire logic [PIX_W-1:0] gfx_pix_i,
	input wire logic [PIX_W-1:0] video_pix_i,
	output logic [PIX_W-1:0] blend_o,
	output logic blend_valid_o,
	// window two settings
	output logic attribute_mode_enable_o,
	output logic gfx_b_active_o,
	output logic gfx_b_table_select_o,
	output logic gfx_b_attenuate_o,
	output logic gfx_b_rgb_mode_o,
	output logic [2:0] gfx_b_horiz_zoom_o,
	output logic [2:0] gfx_b_vert_zoom_o,
	output logic [4:0] gfx_b_bits_per_pixel_o,
	output logic [2:0] gfx_b_blend_ratio_o,
	output logic gfx_b_transparency_enable_o,
	output logic gfx_b_frame_mode_o,
	output logic [LINE_W:0] gfx_b_fetch_line_o,
	output logic blink_enable_o,
	output logic attr_blink_visible_o,
	// cursor
	output logic cursor_active_o,
	output logic [7:0] cursor_palette_index_o,
	output logic cursor_table_select_o,
	output logic [4:0] cursor_horiz_pixels_o,
	output logic [3:0] cursor_vert_lines_o,
	// line pitches
	output logic [8:0] video_a_bursts_per_line_o,
	output logic [8:0] video_b_bursts_per_line_o,
	output logic [8:0] gfx_a_bursts_per_line_o,
	output logic [13:0] video_a_line_bytes_o,
	output logic [13:0] video_b_line_bytes_o,
	output logic [13:0] gfx_a_line_bytes_o
);
	logic [osd_cfg_pkg::NUM_REGS-1:0][15:0] pend;
	logic [osd_cfg_pkg::NUM_REGS-1:0][15:0] shad;
	logic bus_ack;
	logic [2:0] idx;
	logic [15:0] wmask;
	logic [31:0] next_readdata;
	logic vs_meta;
	logic vs_sync;
	logic vs_prev;
	logic vs_pulse;
	logic [4:0] blink_cnt;
	logic blink_phase;
	logic blink_toggle;
	logic [15:0] m;
	logic [15:0] a;
	logic [15:0] c;
	logic attr_on;
	logic [1:0] hz_code;
	logic [1:0] vz_code;
	logic apply_ratio;
	logic [3:0] weight;

	function automatic logic [2:0] reg_index(input logic [4:0] addr);
		unique case (addr)
			osd_cfg_pkg::ADDR_GFX_B_MODE: reg_index = osd_cfg_pkg::IDX_GFX_B;
			osd_cfg_pkg::ADDR_ATTR_MODE: reg_index = osd_cfg_pkg::IDX_ATTR;
			osd_cfg_pkg::ADDR_CURSOR: reg_index = osd_cfg_pkg::IDX_CURSOR;
			osd_cfg_pkg::ADDR_VIDEO_A_PITCH: reg_index = osd_cfg_pkg::IDX_VIDEO_A;
			osd_cfg_pkg::ADDR_VIDEO_B_PITCH: reg_index = osd_cfg_pkg::IDX_VIDEO_B;
			osd_cfg_pkg::ADDR_GFX_A_PITCH: reg_index = osd_cfg_pkg::IDX_GFX_A;
			osd_cfg_pkg::ADDR_STATUS: reg_index = osd_cfg_pkg::IDX_STATUS;
			default: reg_index = osd_cfg_pkg::IDX_NONE;
		endcase
	endfunction : reg_index

	// reserved code 3 falls back to no zoom
	function automatic logic [1:0] zoom_shift(input logic [1:0] code);
		zoom_shift = (code == 2'h3) ? 2'h0 : code;
	endfunction : zoom_shift

	function automatic logic [2:0] zoom_factor(input logic [1:0] code);
		zoom_factor = 3'(3'h1 << zoom_shift(code));
	endfunction : zoom_factor

	function automatic logic [13:0] burst_bytes(input logic [8:0] bursts);
		burst_bytes = {bursts, 5'h00};
	endfunction : burst_bytes

	function automatic logic [PIX_W-1:0] mix(input logic [PIX_W-1:0] g,
		input logic [PIX_W-1:0] v, input logic [3:0] w);
		logic [PIX_W+4:0] sum;
		sum = (PIX_W+5)'(g * w) + (PIX_W+5)'(v * (4'h8 - w));
		mix = sum[PIX_W+2:3];
	endfunction : mix

	// register bus slave: one wait cycle, read data loaded while waiting
	assign idx = reg_index(avs_address_i);
	// a frozen clock holds the wait so the write cannot be lost while disabled
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~(bus_ack & clk_en_i);
	assign wmask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

	always_comb begin
		next_readdata = 32'h0000_0000;
		if (idx == osd_cfg_pkg::IDX_ATTR) begin
			next_readdata[15:0] = {pend[osd_cfg_pkg::IDX_GFX_B][osd_cfg_pkg::ATTR_EN_BIT],
				pend[osd_cfg_pkg::IDX_ATTR][14:0]};
		end else if (idx == osd_cfg_pkg::IDX_STATUS) begin
			next_readdata[osd_cfg_pkg::STAT_BLINK_BIT] = blink_phase;
			next_readdata[osd_cfg_pkg::STAT_PENDING_BIT] = (pend != shad);
		end else if (idx < osd_cfg_pkg::IDX_STATUS) begin
			next_readdata[15:0] = pend[idx];
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bus_ack <= 1'b0;
			avs_readdata_o <= 32'h0000_0000;
		end else if (clk_en_i) begin
			bus_ack <= (avs_read_i | avs_write_i) & ~bus_ack;
			if (avs_read_i && !bus_ack) begin
				avs_readdata_o <= next_readdata;
			end
		end
	end

	// pending copies take writes at once; display sees them only after vsync
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pend <= {osd_cfg_pkg::NUM_REGS{osd_cfg_pkg::RESET_VALUE}};
		end else if (clk_en_i && avs_write_i && bus_ack && idx < osd_cfg_pkg::IDX_STATUS) begin
			pend[idx] <= ((pend[idx] & ~wmask) | (avs_writedata_i[15:0] & wmask))
				& osd_cfg_pkg::WR_MASK[idx];
			if (idx == osd_cfg_pkg::IDX_ATTR && avs_byteenable_i[1]) begin
				pend[osd_cfg_pkg::IDX_GFX_B][osd_cfg_pkg::ATTR_EN_BIT] <=
					avs_writedata_i[osd_cfg_pkg::ATTR_EN_BIT];
			end
		end
	end

	// vsync arrives from the timing generator pin
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			vs_meta <= 1'b0;
			vs_sync <= 1'b0;
			vs_prev <= 1'b0;
		end else if (clk_en_i) begin
			vs_meta <= vertical_sync_pulse_i;
			vs_sync <= vs_meta;
			vs_prev <= vs_sync;
		end
	end
	assign vs_pulse = vs_sync & ~vs_prev;

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			shad <= {osd_cfg_pkg::NUM_REGS{osd_cfg_pkg::RESET_VALUE}};
		end else if (clk_en_i && vs_pulse) begin
			shad <= pend;
		end
	end

	// decoded views of the latched words
	assign m = shad[osd_cfg_pkg::IDX_GFX_B];
	assign a = shad[osd_cfg_pkg::IDX_ATTR];
	assign c = shad[osd_cfg_pkg::IDX_CURSOR];
	assign attr_on = m[osd_cfg_pkg::ATTR_EN_BIT];
	assign attribute_mode_enable_o = attr_on;
	assign gfx_b_active_o = ~attr_on & m[osd_cfg_pkg::ACTIVE_BIT];
	assign gfx_b_table_select_o = ~attr_on & m[osd_cfg_pkg::TABLE_BIT];
	assign gfx_b_attenuate_o = ~attr_on & m[osd_cfg_pkg::ATTEN_BIT];
	assign gfx_b_rgb_mode_o = ~attr_on & m[osd_cfg_pkg::RGB_BIT];
	assign hz_code = attr_on ? a[osd_cfg_pkg::HZOOM_LSB +: 2] : m[osd_cfg_pkg::HZOOM_LSB +: 2];
	assign vz_code = attr_on ? a[osd_cfg_pkg::VZOOM_LSB +: 2] : m[osd_cfg_pkg::VZOOM_LSB +: 2];
	assign gfx_b_horiz_zoom_o = zoom_factor(hz_code);
	assign gfx_b_vert_zoom_o = zoom_factor(vz_code);
	// rgb input forces 16 bits and ignores the width field
	assign gfx_b_bits_per_pixel_o = gfx_b_rgb_mode_o ? osd_cfg_pkg::RGB_BPP :
		5'(5'h01 << m[osd_cfg_pkg::BPP_LSB +: 2]);
	assign gfx_b_blend_ratio_o = m[osd_cfg_pkg::BLEND_LSB +: 3];
	assign gfx_b_transparency_enable_o = ~attr_on & m[osd_cfg_pkg::TRANSP_BIT];
	assign gfx_b_frame_mode_o = attr_on ? a[osd_cfg_pkg::FRAME_BIT] :
		m[osd_cfg_pkg::FRAME_BIT];
	assign blink_enable_o = attr_on & a[osd_cfg_pkg::BLINK_EN_BIT];

	assign cursor_active_o = c[osd_cfg_pkg::CUR_ACTIVE_BIT];
	assign cursor_palette_index_o = c[osd_cfg_pkg::CUR_INDEX_LSB +: 8];
	assign cursor_table_select_o = c[osd_cfg_pkg::CUR_TABLE_BIT];
	assign cursor_horiz_pixels_o = (c[osd_cfg_pkg::CUR_H_LSB +: 3] == 3'h0) ? 5'h01 :
		{c[osd_cfg_pkg::CUR_H_LSB +: 3], 2'h0};
	assign cursor_vert_lines_o = (c[osd_cfg_pkg::CUR_V_LSB +: 3] == 3'h0) ? 4'h1 :
		{c[osd_cfg_pkg::CUR_V_LSB +: 3], 1'h0};

	assign video_a_bursts_per_line_o = shad[osd_cfg_pkg::IDX_VIDEO_A][8:0];
	assign video_b_bursts_per_line_o = shad[osd_cfg_pkg::IDX_VIDEO_B][8:0];
	assign gfx_a_bursts_per_line_o = shad[osd_cfg_pkg::IDX_GFX_A][8:0];
	assign video_a_line_bytes_o = burst_bytes(video_a_bursts_per_line_o);
	assign video_b_line_bytes_o = burst_bytes(video_b_bursts_per_line_o);
	assign gfx_a_line_bytes_o = burst_bytes(gfx_a_bursts_per_line_o);

	// blink: count vsyncs, toggle after (n+1)*8 of them
	assign blink_toggle = vs_pulse &&
		blink_cnt == {a[osd_cfg_pkg::BLINK_INT_LSB +: 2], osd_cfg_pkg::BLINK_UNIT_LAST};
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			blink_cnt <= 5'h00;
			blink_phase <= 1'b1;
		end else if (clk_en_i) begin
			if (!blink_enable_o) begin
				blink_cnt <= 5'h00;
				blink_phase <= 1'b1;
			end else if (blink_toggle) begin
				blink_cnt <= 5'h00;
				blink_phase <= ~blink_phase;
			end else if (vs_pulse) begin
				blink_cnt <= blink_cnt + 5'h01;
			end
		end
	end
	assign attr_blink_visible_o = blink_phase;

	// stored line to fetch: frame mode interleaves fields, zoom repeats lines
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			gfx_b_fetch_line_o <= '0;
		end else if (clk_en_i) begin
			if (gfx_b_frame_mode_o && video_encoder_interlaced_i) begin
				gfx_b_fetch_line_o <= {display_line_i, field_odd_i} >> zoom_shift(vz_code);
			end else begin
				gfx_b_fetch_line_o <= {1'b0, display_line_i} >> zoom_shift(vz_code);
			end
		end
	end

	// blend: ratio applies to all pixels, or only to transparent ones
	always_comb begin
		if (!gfx_b_transparency_enable_o) begin
			apply_ratio = 1'b1;
		end else if (gfx_b_rgb_mode_o) begin
			apply_ratio = (gfx_rgb_i == transparency_key_i);
		end else begin
			apply_ratio = (gfx_index_i == 8'h00);
		end
		if (!gfx_b_active_o) begin
			weight = 4'h0;
		end else if (!apply_ratio || gfx_b_blend_ratio_o == osd_cfg_pkg::BLEND_FULL) begin
			weight = osd_cfg_pkg::WEIGHT_ONE;
		end else begin
			weight = {1'b0, gfx_b_blend_ratio_o};
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			blend_o <= '0;
			blend_valid_o <= 1'b0;
		end else if (clk_en_i) begin
			blend_valid_o <= pix_valid_i;
			if (pix_valid_i) begin
				blend_o <= mix(gfx_pix_i, video_pix_i, weight);
			end
		end
	end

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rstn_i);

	property p_shadow_hold;
		!(clk_en_i && vs_pulse) |=> $stable(shad);
	endproperty
	a_shadow_hold: assert property (p_shadow_hold) else $error("shadow moved without vsync");

	property p_shadow_take;
		(clk_en_i && vs_pulse) |=> shad == $past(pend);
	endproperty
	a_shadow_take: assert property (p_shadow_take) else $error("shadow missed vsync copy");

	property p_hzoom_reserved;
		(!attr_on && m[11:10] == 2'h3) |-> gfx_b_horiz_zoom_o == 3'h1;
	endproperty
	a_hzoom_reserved: assert property (p_hzoom_reserved) else $error("zoom code 3 not x1");

	property p_vzoom_attr;
		(attr_on && a[9:8] == 2'h2) |-> gfx_b_vert_zoom_o == 3'h4;
	endproperty
	a_vzoom_attr: assert property (p_vzoom_attr) else $error("attribute zoom not x4");

	property p_bpp_eight;
		(!attr_on && !m[13] && m[7:6] == 2'h3) |-> gfx_b_bits_per_pixel_o == 5'h08;
	endproperty
	a_bpp_eight: assert property (p_bpp_eight) else $error("width code 3 not 8 bits");

	property p_blend_video_only;
		(clk_en_i && pix_valid_i && gfx_b_active_o && !gfx_b_transparency_enable_o
			&& gfx_b_blend_ratio_o == 3'h0) |=> blend_o == $past(video_pix_i);
	endproperty
	a_blend_video_only: assert property (p_blend_video_only) else $error("ratio 0 not video");

	property p_attr_hides;
		attr_on |-> !gfx_b_active_o && !gfx_b_table_select_o;
	endproperty
	a_attr_hides: assert property (p_attr_hides) else $error("window shown in attribute mode");

	property p_cursor_width;
		c[6:4] == 3'h5 |-> cursor_horiz_pixels_o == 5'h14 && cursor_vert_lines_o != 4'h0;
	endproperty
	a_cursor_width: assert property (p_cursor_width) else $error("cursor width wrong");

	property p_cursor_height;
		c[3:1] == 3'h0 |-> cursor_vert_lines_o == 4'h1;
	endproperty
	a_cursor_height: assert property (p_cursor_height) else $error("cursor height wrong");

	property p_blink_period;
		(clk_en_i && blink_enable_o && blink_phase != $past(blink_phase) && $past(blink_enable_o))
			|-> $past(blink_cnt) == {$past(a[7:6]), 3'h7};
	endproperty
	a_blink_period: assert property (p_blink_period) else $error("blink toggled off period");

	property p_frame_field;
		(clk_en_i && gfx_b_frame_mode_o && video_encoder_interlaced_i && vz_code == 2'h0)
			|=> gfx_b_fetch_line_o[0] == $past(field_odd_i);
	endproperty
	a_frame_field: assert property (p_frame_field) else $error("frame mode line parity");

	c_attr_latched: cover property (vs_pulse && clk_en_i && pend[0][15] ##1 attr_on);
	c_blink_toggle: cover property (clk_en_i && blink_toggle && blink_enable_o);
	c_keyed_blend: cover property (pix_valid_i && gfx_b_rgb_mode_o
		&& gfx_b_transparency_enable_o && gfx_rgb_i == transparency_key_i);
endmodule : osd_window_layer_config

// ==== test_osd_window_layer_config.sv ====
// register-level testbench of the overlay window configuration bank
`timescale 1ns/100ps
module test_osd_window_layer_config;
	logic sys_clk_i = 1'b0;
	logic rstn_i, clk_en_i, avs_read_i, avs_write_i, vertical_sync_pulse_i;
	logic video_encoder_interlaced_i, field_odd_i, pix_valid_i;
	logic [4:0] avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o;
	logic [3:0] avs_byteenable_i;
	logic avs_waitrequest_o, blend_valid_o, attribute_mode_enable_o, gfx_b_active_o;
	logic gfx_b_table_select_o, gfx_b_attenuate_o, gfx_b_rgb_mode_o, blink_enable_o;
	logic gfx_b_transparency_enable_o, gfx_b_frame_mode_o, attr_blink_visible_o;
	logic cursor_active_o, cursor_table_select_o;
	logic [10:0] display_line_i;
	logic [7:0] gfx_index_i, gfx_pix_i, video_pix_i, blend_o, cursor_palette_index_o;
	logic [15:0] gfx_rgb_i, transparency_key_i;
	logic [2:0] gfx_b_horiz_zoom_o, gfx_b_vert_zoom_o, gfx_b_blend_ratio_o;
	logic [4:0] gfx_b_bits_per_pixel_o, cursor_horiz_pixels_o;
	logic [11:0] gfx_b_fetch_line_o;
	logic [3:0] cursor_vert_lines_o;
	logic [8:0] video_a_bursts_per_line_o, video_b_bursts_per_line_o, gfx_a_bursts_per_line_o;
	logic [13:0] video_a_line_bytes_o, video_b_line_bytes_o, gfx_a_line_bytes_o;
	int err_total = 0;
	int n_checks = 0;
	logic [31:0] rd;
	int i, tog;
	logic ph;
	logic [2:0] r;

	osd_window_layer_config dut (.*);

	always #5 sys_clk_i = ~sys_clk_i;

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// waitrequest is sampled before each rising edge, so the decision matches that edge
	task automatic bus_wait(output logic [31:0] d);
		int k;
		logic w;
		for (k = 0; k < 50; k++) begin
			@(negedge sys_clk_i);
			w = avs_waitrequest_o;
			d = avs_readdata_o;
			@(posedge sys_clk_i);
			if (w === 1'b0)
				break;
		end
		if (k == 50) begin
			err_total++;
			$display("[ERR] bus wait expected 0 seen timeout");
			stop_test();
		end
	endtask : bus_wait

	task automatic bus_write(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] x;
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= 1'b1;
		bus_wait(x);
		avs_write_i <= 1'b0;
		@(posedge sys_clk_i);
	endtask : bus_write

	task automatic bus_read(input logic [4:0] a, output logic [31:0] d);
		avs_address_i <= a;
		avs_read_i <= 1'b1;
		bus_wait(d);
		avs_read_i <= 1'b0;
		@(posedge sys_clk_i);
	endtask : bus_read

	task automatic vsync();
		vertical_sync_pulse_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		vertical_sync_pulse_i <= 1'b0;
		repeat (7) @(posedge sys_clk_i);
	endtask : vsync

	function automatic logic [2:0] zf(input logic [1:0] c);
		return (c == 2'h1) ? 3'h2 : (c == 2'h2) ? 3'h4 : 3'h1;
	endfunction : zf

	task automatic pix(input logic [7:0] idx, input logic [7:0] exp);
		gfx_index_i <= idx;
		pix_valid_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		check("blend", blend_o, exp);
		check("blend valid", blend_valid_o, 32'h1);
		@(posedge sys_clk_i);
		pix_valid_i <= 1'b0;
		@(posedge sys_clk_i);
	endtask : pix

	initial begin
		rstn_i = 1'b0; clk_en_i = 1'b1; avs_read_i = 1'b0; avs_write_i = 1'b0;
		avs_address_i = 5'h00; avs_writedata_i = 32'h0; avs_byteenable_i = 4'hF;
		vertical_sync_pulse_i = 1'b0; video_encoder_interlaced_i = 1'b1; field_odd_i = 1'b0;
		display_line_i = 11'h005; pix_valid_i = 1'b0; gfx_index_i = 8'h00;
		gfx_rgb_i = 16'h1234; transparency_key_i = 16'h1234;
		gfx_pix_i = 8'h80; video_pix_i = 8'h00;
		repeat (10) @(posedge sys_clk_i);
		rstn_i <= 1'b1;
		@(posedge sys_clk_i);
		// reset values and unmapped space
		for (i = 0; i < 6; i++) begin
			bus_read(5'(i * 4), rd);
			check("reset value", rd, 32'h0);
		end
		check("cursor width", cursor_horiz_pixels_o, 32'h1);
		check("cursor height", cursor_vert_lines_o, 32'h1);
		check("cursor off", cursor_active_o, 32'h0);
		bus_read(osd_cfg_pkg::ADDR_STATUS, rd);
		check("status", rd, 32'h1);
		bus_write(5'h1C, 32'hFFFF_FFFF);
		bus_read(5'h1C, rd);
		check("unmapped", rd, 32'h0);
		$display("test reset done");
		// window two zoom, width, table and active codes
		for (i = 0; i < 4; i++) begin
			bus_write(osd_cfg_pkg::ADDR_GFX_B_MODE, 32'(i[0] << 12 | i << 10 | i << 8 | i << 6 | 1));
			check("pre-vsync active", gfx_b_active_o, 32'(i != 0 ? 1 : 0));
			vsync();
			check("hzoom", gfx_b_horiz_zoom_o, 32'(zf(i[1:0])));
			check("vzoom", gfx_b_vert_zoom_o, 32'(zf(i[1:0])));
			check("bpp", gfx_b_bits_per_pixel_o, 32'(1 << i));
			check("table", gfx_b_table_select_o, 32'(i[0]));
			check("active", gfx_b_active_o, 32'h1);
		end
		$display("test window modes done");
		// blending and transparency on window two
		for (i = 0; i < 3; i++) begin
			r = (i == 0) ? 3'h0 : (i == 1) ? 3'h3 : 3'h7;
			bus_write(osd_cfg_pkg::ADDR_GFX_B_MODE, {26'h0, r, 3'h1});
			vsync();
			check("ratio", gfx_b_blend_ratio_o, 32'(r));
			pix(8'h05, (r == 3'h7) ? 8'h80 : {1'b0, r, 4'h0});
		end
		bus_write(osd_cfg_pkg::ADDR_GFX_B_MODE, 32'h0000_001D);
		vsync();
		check("transp", gfx_b_transparency_enable_o, 32'h1);
		pix(8'h00, 8'h30);
		pix(8'h05, 8'h80);
		bus_write(osd_cfg_pkg::ADDR_GFX_B_MODE, 32'h0000_601D);
		vsync();
		check("rgb", gfx_b_rgb_mode_o, 32'h1);
		check("attenuate", gfx_b_attenuate_o, 32'h1);
		check("rgb bpp", gfx_b_bits_per_pixel_o, 32'h10);
		pix(8'h05, 8'h30);
		transparency_key_i <= 16'h0000;
		pix(8'h00, 8'h80);
		$display("test blend done");
		// line fetch in field and frame display modes
		field_odd_i <= 1'b1;
		bus_write(osd_cfg_pkg::ADDR_GFX_B_MODE, 32'h0000_0001);
		vsync();
		check("field fetch", gfx_b_fetch_line_o, 32'h5);
		bus_write(osd_cfg_pkg::ADDR_GFX_B_MODE, 32'h0000_0003);
		vsync();
		check("frame fetch", gfx_b_fetch_line_o, 32'hB);
		video_encoder_interlaced_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		check("progressive fetch", gfx_b_fetch_line_o, 32'h5);
		video_encoder_interlaced_i <= 1'b1;
		$display("test fetch done");
		// attribute window
		bus_write(osd_cfg_pkg::ADDR_ATTR_MODE, 32'h0000_8603);
		bus_read(osd_cfg_pkg::ADDR_ATTR_MODE, rd);
		check("attr read", rd, 32'h8603);
		check("pre-vsync attr", attribute_mode_enable_o, 32'h0);
		vsync();
		check("attr enable", attribute_mode_enable_o, 32'h1);
		check("attr hides active", gfx_b_active_o, 32'h0);
		check("attr hzoom", gfx_b_horiz_zoom_o, 32'h2);
		check("attr vzoom", gfx_b_vert_zoom_o, 32'h4);
		check("attr frame", gfx_b_frame_mode_o, 32'h1);
		check("blink", blink_enable_o, 32'h1);
		tog = 0;
		ph = attr_blink_visible_o;
		for (i = 0; i < 16; i++) begin
			vsync();
			if (attr_blink_visible_o !== ph)
				tog++;
			ph = attr_blink_visible_o;
		end
		check("blink toggles", 32'(tog), 32'h2);
		bus_write(osd_cfg_pkg::ADDR_ATTR_MODE, 32'h0);
		vsync();
		$display("test attribute done");
		// cursor widths and colour
		for (i = 0; i < 8; i++) begin
			bus_write(osd_cfg_pkg::ADDR_CURSOR, 32'(8'hA5 ^ i) << 8 | 32'(i[0] << 7 | i << 4 | i << 1 | 1));
			vsync();
			check("cursor width", cursor_horiz_pixels_o, i ? 32'(4 * i) : 32'h1);
			check("cursor height", cursor_vert_lines_o, i ? 32'(2 * i) : 32'h1);
			check("cursor index", cursor_palette_index_o, 32'(8'hA5 ^ i));
			check("cursor table", cursor_table_select_o, 32'(i[0]));
			check("cursor active", cursor_active_o, 32'h1);
		end
		$display("test cursor done");
		// line pitches
		bus_write(osd_cfg_pkg::ADDR_VIDEO_A_PITCH, 32'hFFFF_FFFF);
		bus_write(osd_cfg_pkg::ADDR_VIDEO_B_PITCH, 32'h0000_002D);
		bus_write(osd_cfg_pkg::ADDR_GFX_A_PITCH, 32'h0000_0010);
		bus_read(osd_cfg_pkg::ADDR_VIDEO_A_PITCH, rd);
		check("pitch reserved", rd, 32'h1FF);
		bus_read(osd_cfg_pkg::ADDR_STATUS, rd);
		check("status pending", rd, 32'h3);
		check("pre-vsync pitch", video_b_bursts_per_line_o, 32'h0);
		vsync();
		check("video a bursts", video_a_bursts_per_line_o, 32'h1FF);
		check("video a bytes", video_a_line_bytes_o, 32'h3FE0);
		check("video b bytes", video_b_line_bytes_o, 32'h5A0);
		check("gfx a bursts", gfx_a_bursts_per_line_o, 32'h10);
		check("gfx a bytes", gfx_a_line_bytes_o, 32'h200);
		bus_write(osd_cfg_pkg::ADDR_VIDEO_B_PITCH, 32'h0000_002E);
		clk_en_i <= 1'b0;
		vsync();
		check("frozen pitch", video_b_bursts_per_line_o, 32'h2D);
		clk_en_i <= 1'b1;
		vsync();
		check("thawed pitch", video_b_bursts_per_line_o, 32'h2E);
		$display("test pitch done");
		stop_test();
	end
endmodule : test_osd_window_layer_config
